// File: tcp_mcu_model.sv
// Far-side microcontroller model: strap, UART and open-drain nodes.
// Assumes the bench commands it on sys_clk; pads use the package struct.
`timescale 1ns/1ps

module tcp_mcu_model (
  // Clock
  input  wire logic        sys_clk,
  // Commands from the bench
  input  wire logic        mode_cmd,
  input  wire logic        ext_en,
  input  wire logic        tx_bit,
  input  wire logic        rts_bit,
  // Pads driven by the block
  input  tcp_pkg::tcp_pad_t en_pad,
  input  tcp_pkg::tcp_pad_t sda_pad,
  // Pins seen by the block
  output logic             mode_sel,
  output logic             tx_data_in,
  output logic             line_drv_enable_in,
  output logic             enable_power_good_in,
  output logic             busdata_in
);
  //////////////////////////////////////////////////////////////////////
  // Pins move just after an edge, as firmware would set them
  always_ff @(posedge sys_clk) begin
    mode_sel           <= mode_cmd;
    tx_data_in         <= tx_bit;
    line_drv_enable_in <= rts_bit;
  end
  // Pull-up node: either party pulling low wins
  assign enable_power_good_in = ext_en & ~(en_pad.oe & ~en_pad.out);
  // Data line idles high; the wake flag pulls it low
  assign busdata_in = ~(sda_pad.oe & ~sda_pad.out);
endmodule // tcp_mcu_model

// File: tcp_params.svh
// Constants of the transceiver control-pin block: offsets, bits, resets
// and timing. Assumes a 200 MHz system clock.
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

// Register offsets
`define TCP_CTRL_OFS        8'h00
`define TCP_STAT_OFS        8'h04
// Control register bit positions
`define TCP_CTRL_DRV_EN     0
`define TCP_CTRL_AUX_DIS    1
`define TCP_CTRL_RX_DIS     2
`define TCP_CTRL_TX_NOINV   3
`define TCP_CTRL_CLK_ON     4
`define TCP_CTRL_ILIM_LO    5
`define TCP_CTRL_ILIM_HI    6
// Control register reset value: driver off, outputs on, 200 mA limit
`define TCP_CTRL_RESET      8'h50
// Status register bit positions
`define TCP_STAT_SERIAL     0
`define TCP_STAT_ADDR       1
`define TCP_STAT_EN         2
`define TCP_STAT_PULL       3
`define TCP_STAT_DRV        4
`define TCP_STAT_WAKE       5
// Serial-bus target base address (arbitrary value)
`define TCP_TARGET_BASE     7'h3_0
// Supply monitor thresholds in millivolts
`define TCP_V5_LOW_MV       13'd3000
`define TCP_V5_HIGH_MV      13'd3500
// Timing
`define TCP_CLK_PERIOD_PS   5000
`define TCP_WAKE_HOLD_NS    1000
// Clock output phase step: 14.74 MHz / 200 MHz * 2^32
`define TCP_NCO_STEP        32'h12DE_00D2

`endif

// File: tcp_pgood.sv
// Supply monitor with hysteresis for the enable/power-good pin.
// Assumes a sampled 5 V rail reading in millivolts on sys_clk.
`timescale 1ns/1ps
`include "tcp_params.svh"

module tcp_pgood (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Rail reading and pull request
  input  wire logic [12:0] v5_mv,
  output logic             pull_low
);

  logic pull_reg, pull_next;

  // Two thresholds keep the pin from chattering near the trip point
  always_comb begin
    pull_next = pull_reg;
    if (v5_mv < `TCP_V5_LOW_MV)
      pull_next = 1'b1;
    else if (v5_mv > `TCP_V5_HIGH_MV)
      pull_next = 1'b0;
  end

  // Pull low from reset until the rail is seen good
  always_ff @(posedge sys_clk) begin
    if (reset) pull_reg <= 1'b1;
    else       pull_reg <= pull_next;
  end

  assign pull_low = pull_reg;

  a_pull_low_trip: assert property (
    @(posedge sys_clk) disable iff (reset)
    (v5_mv < `TCP_V5_LOW_MV) |=> pull_low)
    else $error("pin not pulled low under low rail");

  a_pull_hold_band: assert property (
    @(posedge sys_clk) disable iff (reset)
    (v5_mv >= `TCP_V5_LOW_MV && v5_mv <= `TCP_V5_HIGH_MV)
      |=> pull_low == $past(pull_low))
    else $error("pull changed inside hysteresis band");

endmodule // tcp_pgood

// File: tcp_pin_logic.sv
// Control-pin logic of a 24 V line transceiver: mode strap, dual-use
// pins, driver gating, receiver outputs, clock output and registers.
// Assumes pins are asynchronous and the register port is on sys_clk.
//
// Functional notes
// - A static strap level selects serial-bus control (high) or pin control.
// - In serial mode the address/clock-enable pin picks the target address.
// - In pin mode that pin high enables the clock output, low floats it.
// - In pin mode the clock output runs at a fixed 14.74 MHz.
// - In pin mode the limit-select pin high picks 100 mA, low picks 200 mA.
// - In pin mode the data/wake pin is an output flagging a line wake-up.
// - The auxiliary receiver output is the inverse of the auxiliary input.
// - In serial mode the auxiliary disable bit floats that output.
// - In pin mode the auxiliary receiver output is always driven.
// - Enable pin high runs the device, low disables it.
// - Enable low turns the driver off and, in serial mode, resets registers.
// - The device pulls the enable pin low below 3 V and frees it above 3.5 V.
// - In serial mode the driver runs only with enable bit and input high.
// - In pin mode the driver-enable input and the enable pin gate the driver.
// - The line output is by default the inverse of the transmit input.
// - The line receiver output inverts the line; serial-mode bit floats it.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "tcp_params.svh"

module tcp_pin_logic (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  // Strap and dual-use pins
  input  wire logic                mode_sel,
  input  wire logic                addr_sel_clkout_en,
  input  wire logic                busclk_or_ilim_sel,
  input  wire logic                busdata_or_wake_flag_in,
  output tcp_pkg::tcp_pad_t        busdata_or_wake_flag,
  // Enable / power-good open-drain pin
  input  wire logic                enable_power_good_in,
  output tcp_pkg::tcp_pad_t        enable_power_good,
  // Transmit side
  input  wire logic                tx_data_in,
  input  wire logic                line_drv_enable_in,
  output tcp_pkg::tcp_pad_t        line_drv,
  output tcp_pkg::tcp_ilim_t       ilim_sel,
  // Receive side
  input  wire logic                line_in,
  input  wire logic                aux_line_in,
  output tcp_pkg::tcp_pad_t        line_rx_out,
  output tcp_pkg::tcp_pad_t        aux_rx_out,
  // Clock output, wake detector, rail monitor, serial-bus engine
  output tcp_pkg::tcp_pad_t        clkout,
  input  wire logic                wake_detect,
  input  wire logic [12:0]         v5_mv,
  output logic      [6:0]          bus_target_addr,
  output logic                     bus_scl,
  output logic                     bus_sda
);

  localparam int WAKE_HOLD_CYC =
    (`TCP_WAKE_HOLD_NS * 1000 + `TCP_CLK_PERIOD_PS - 1) / `TCP_CLK_PERIOD_PS;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [8:0] pin_raw;
  logic [8:0] pin_s;
  logic       mode_s, addr_s, scl_s, sda_s, en_pin_s;
  logic       tx_s, drv_en_s, line_s, aux_s;

  assign pin_raw = {mode_sel, addr_sel_clkout_en, busclk_or_ilim_sel,
                    busdata_or_wake_flag_in, enable_power_good_in,
                    tx_data_in, line_drv_enable_in, line_in, aux_line_in};
  assign {mode_s, addr_s, scl_s, sda_s, en_pin_s,
          tx_s, drv_en_s, line_s, aux_s} = pin_s;

  tcp_sync #(.W(9)) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .d       (pin_raw),
    .q       (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Mode and enable

  tcp_pkg::tcp_mode_t mode;
  logic               serial, pin_mode, pull_low, en_eff;

  // Strap is static; a level change simply re-steers the pins
  assign mode     = tcp_pkg::tcp_mode_t'(mode_s);
  assign serial   = (mode == tcp_pkg::TCP_MODE_SERIAL);
  assign pin_mode = (mode == tcp_pkg::TCP_MODE_PIN);

  tcp_pgood u_pgood (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .v5_mv    (v5_mv),
    .pull_low (pull_low)
  );

  // Wired-AND: the internal pull wins even before the pin reflects it
  assign en_eff = en_pin_s & ~pull_low;

  ////////////////////////////////////////////////////////////////////////
  // Registers

  tcp_pkg::tcp_ctrl_t ctrl_reg, ctrl_next;
  logic               wake_sticky_reg, wake_sticky_next;
  logic [7:0]         rdata_reg, rdata_next;
  logic [7:0]         status;
  logic               drv_on;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign status = {2'b00, wake_sticky_reg, drv_on, pull_low, en_eff,
                   addr_s, serial};

  // Write decode; a wake in the clearing cycle survives the clear
  always_comb begin
    ctrl_next        = ctrl_reg;
    wake_sticky_next = wake_sticky_reg;
    rdata_next       = 8'h00;
    if (reg_wr && hit(reg_addr, `TCP_CTRL_OFS))
      ctrl_next = tcp_pkg::tcp_ctrl_t'(reg_wdata);
    if (reg_wr && hit(reg_addr, `TCP_STAT_OFS) &&
        reg_wdata[`TCP_STAT_WAKE])
      wake_sticky_next = 1'b0;
    if (serial && wake_detect)
      wake_sticky_next = 1'b1;
    if (reg_rd && hit(reg_addr, `TCP_CTRL_OFS))
      rdata_next = ctrl_reg;
    else if (reg_rd && hit(reg_addr, `TCP_STAT_OFS))
      rdata_next = status;
    if (serial && !en_eff) begin
      ctrl_next        = tcp_pkg::tcp_ctrl_t'(`TCP_CTRL_RESET);
      wake_sticky_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_reg        <= tcp_pkg::tcp_ctrl_t'(`TCP_CTRL_RESET);
      wake_sticky_reg <= 1'b0;
      rdata_reg       <= 8'h00;
    end else begin
      ctrl_reg        <= ctrl_next;
      wake_sticky_reg <= wake_sticky_next;
      rdata_reg       <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Clock output phase accumulator

  logic [31:0] nco_reg, nco_next;

  // Fractional step gives the right mean rate; edges jitter by one cycle
  always_comb begin
    nco_next = nco_reg + `TCP_NCO_STEP;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) nco_reg <= 32'h0000_0000;
    else       nco_reg <= nco_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake flag stretcher

  logic [7:0] wake_cnt_reg, wake_cnt_next;

  // A short detector pulse is held long enough for slow logic to see it
  always_comb begin
    wake_cnt_next = wake_cnt_reg;
    if (pin_mode && wake_detect)
      wake_cnt_next = 8'(WAKE_HOLD_CYC);
    else if (wake_cnt_reg != 8'h00)
      wake_cnt_next = wake_cnt_reg - 8'h01;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) wake_cnt_reg <= 8'h00;
    else       wake_cnt_reg <= wake_cnt_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pad outputs

  tcp_pkg::tcp_pad_t  drv_reg, drv_next, rx_reg, rx_next;
  tcp_pkg::tcp_pad_t  aux_reg, aux_next, clk_reg, clk_next;
  tcp_pkg::tcp_pad_t  sda_pad_reg, sda_pad_next, en_pad_reg, en_pad_next;
  tcp_pkg::tcp_ilim_t ilim_reg, ilim_next;
  logic [6:0]         tgt_reg, tgt_next;

  // Driver gating differs by mode; enable low always forces it off
  always_comb begin
    if (serial)
      drv_on = en_eff & ctrl_reg.drv_en & drv_en_s;
    else
      drv_on = en_eff & drv_en_s;
  end

  always_comb begin
    // Line driver inverts transmit data unless told not to
    drv_next.oe  = drv_on;
    drv_next.out = (serial && ctrl_reg.tx_noinv) ? tx_s : ~tx_s;
    // Receivers invert their inputs; floats only under serial control
    rx_next.out  = ~line_s;
    rx_next.oe   = ~(serial & ctrl_reg.rx_dis);
    aux_next.out = ~aux_s;
    aux_next.oe  = pin_mode ? 1'b1 :
                   ~ctrl_reg.aux_dis;
    // Clock output: pin-enabled in pin mode, register-enabled otherwise
    clk_next.out = nco_reg[31];
    clk_next.oe  = pin_mode ? addr_s : ctrl_reg.clk_on;
    // Wake flag is active low and only driven while flagged
    sda_pad_next.out = 1'b0;
    sda_pad_next.oe  = pin_mode && (wake_cnt_reg != 8'h00);
    // Open-drain power-good: pull low only, never drive high
    en_pad_next.out  = 1'b0;
    en_pad_next.oe   = pull_low;
    // Current limit: pin picks 100 or 200 mA in pin mode
    if (pin_mode)
      ilim_next = scl_s ? tcp_pkg::TCP_ILIM_100 :
                          tcp_pkg::TCP_ILIM_200;
    else
      ilim_next = ctrl_reg.ilim;
    // Target address low bit follows the address pin
    tgt_next = {6'(`TCP_TARGET_BASE >> 1), addr_s};
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      drv_reg     <= '0;
      rx_reg      <= '0;
      aux_reg     <= '0;
      clk_reg     <= '0;
      sda_pad_reg <= '0;
      en_pad_reg  <= '{out: 1'b0, oe: 1'b1};
      ilim_reg    <= tcp_pkg::TCP_ILIM_200;
      tgt_reg     <= 7'h00;
    end else begin
      drv_reg     <= drv_next;
      rx_reg      <= rx_next;
      aux_reg     <= aux_next;
      clk_reg     <= clk_next;
      sda_pad_reg <= sda_pad_next;
      en_pad_reg  <= en_pad_next;
      ilim_reg    <= ilim_next;
      tgt_reg     <= tgt_next;
    end
  end

  assign line_drv             = drv_reg;
  assign line_rx_out          = rx_reg;
  assign aux_rx_out           = aux_reg;
  assign clkout               = clk_reg;
  assign busdata_or_wake_flag = sda_pad_reg;
  assign enable_power_good    = en_pad_reg;
  assign ilim_sel             = ilim_reg;
  assign bus_target_addr      = tgt_reg;
  // Serial-bus engine sees the synchronised pins only in serial mode
  assign bus_scl              = serial & scl_s;
  assign bus_sda              = serial & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_drv_serial_gate: assert property (
    serial && !(ctrl_reg.drv_en && drv_en_s) |=> !line_drv.oe)
    else $error("driver on without enable bit and input");

  a_drv_pin_gate: assert property (
    pin_mode && en_eff |=> line_drv.oe == $past(drv_en_s))
    else $error("pin-mode driver not following enable input");

  a_drv_off_disabled: assert property (
    !en_eff |=> !line_drv.oe)
    else $error("driver on while device disabled");

  a_regs_reset_off: assert property (
    serial && !en_eff |=> ctrl_reg == tcp_pkg::tcp_ctrl_t'(`TCP_CTRL_RESET))
    else $error("registers not reset while disabled");

  a_clk_pin_enable: assert property (
    pin_mode |=> clkout.oe == $past(addr_s))
    else $error("clock output enable not following pin");

  a_aux_inverse: assert property (
    1'b1 |=> aux_rx_out.out == !$past(aux_s))
    else $error("aux output not inverse of input");

  a_aux_float_bit: assert property (
    serial && ctrl_reg.aux_dis |=> !aux_rx_out.oe)
    else $error("aux output driven while disabled");

  a_aux_pin_on: assert property (
    pin_mode |=> aux_rx_out.oe)
    else $error("aux output floated in pin mode");

  a_rx_inverse: assert property (
    !(serial && ctrl_reg.rx_dis) |=> rx_reg.oe && rx_reg.out == !$past(line_s))
    else $error("line receiver output wrong");

  a_ilim_pin_sel: assert property (
    pin_mode |=> ilim_sel == ($past(scl_s) ? tcp_pkg::TCP_ILIM_100 :
                                             tcp_pkg::TCP_ILIM_200))
    else $error("current limit not following pin");

  a_wake_flag_hold: assert property (
    pin_mode && wake_detect |=> ##1 busdata_or_wake_flag.oe [*8])
    else $error("wake flag not held after detection");

  a_tx_inverse: assert property (
    serial && !ctrl_reg.tx_noinv |=> line_drv.out == !$past(tx_s))
    else $error("line output not inverse of transmit data");

  a_en_wired_and: assert property (
    pull_low |-> !en_eff ##1 enable_power_good.oe)
    else $error("internal pull not forcing enable low");

endmodule // tcp_pin_logic

// File: tcp_pkg.sv
// Types of the transceiver control-pin block.
// Constants live in tcp_params.svh.
package tcp_pkg;

  // Control style picked by the strap
  typedef enum logic {
    TCP_MODE_PIN    = 1'b0,
    TCP_MODE_SERIAL = 1'b1
  } tcp_mode_t;

  // Driver current limit code
  typedef enum logic [1:0] {
    TCP_ILIM_50  = 2'b00,
    TCP_ILIM_100 = 2'b01,
    TCP_ILIM_200 = 2'b10,
    TCP_ILIM_250 = 2'b11
  } tcp_ilim_t;

  // One three-state or open-drain pad: level and enable
  typedef struct packed {
    logic out;
    logic oe;
  } tcp_pad_t;

  // Control register layout, bit 7 first
  typedef struct packed {
    logic      spare;
    tcp_ilim_t ilim;
    logic      clk_on;
    logic      tx_noinv;
    logic      rx_dis;
    logic      aux_dis;
    logic      drv_en;
  } tcp_ctrl_t;

endpackage

// File: tcp_sync.sv
// Two-flop synchroniser, one chain per bit.
// Assumes inputs are asynchronous pin levels.
`timescale 1ns/1ps

module tcp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg, s1_next, s2_reg, s2_next;
      // First stage feeds only the second
      always_comb begin
        s1_next = d[i];
        s2_next = s1_reg;
      end
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
        end else begin
          s1_reg <= s1_next;
          s2_reg <= s2_next;
        end
      end
      assign q[i] = s2_reg;
    end
  endgenerate

endmodule // tcp_sync

// File: transceiver_ctrl_pin_logic_bench.sv
// Self-checking bench for the transceiver control-pin block.
// Assumes tcp_pkg, tcp_params.svh and tcp_mcu_model are compiled first.
`timescale 1ns/1ps
`include "tcp_params.svh"

module transceiver_ctrl_pin_logic_bench;
  typedef struct packed {
    logic [3:0] sel;
    logic       m;
    logic [7:0] v;
  } tcp_note_t;
  localparam logic [3:0] S_AUX = 4'h1, S_RX = 4'h2, S_DRV = 4'h3;
  localparam logic [3:0] S_CLK = 4'h4, S_WK = 4'h5, S_EN = 4'h6;
  localparam logic [3:0] S_IL = 4'h7, S_ADR = 4'h8, S_BUS = 4'h9;
  localparam logic [6:0] TBASE = `TCP_TARGET_BASE;
  logic               sys_clk = 1'b0;
  logic               reset, reg_wr, reg_rd, rd_seen, snap, prev;
  logic [7:0]         reg_addr, reg_wdata, reg_rdata;
  logic               mode_cmd, ext_en, tx_bit, rts_bit, mode_sel;
  logic               tx_data_in, line_drv_enable_in, en_in, sda_in;
  logic               addr_sel_clkout_en, busclk_or_ilim_sel, line_in;
  logic               aux_line_in, wake_detect;
  logic [12:0]        v5_mv;
  logic [6:0]         bus_target_addr;
  logic               bus_scl, bus_sda;
  tcp_pkg::tcp_pad_t  busdata_or_wake_flag, enable_power_good, line_drv;
  tcp_pkg::tcp_pad_t  line_rx_out, aux_rx_out, clkout;
  tcp_pkg::tcp_ilim_t ilim_sel;
  tcp_note_t          notes[$];
  tcp_note_t          nt;
  logic [31:0]        rs;
  int                 num_errors = 0, n_checks = 0, cnt;
  //////////////////////////////////////////////////////////////////////
  tcp_pin_logic i_dut (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode_sel(mode_sel),
    .addr_sel_clkout_en(addr_sel_clkout_en),
    .busclk_or_ilim_sel(busclk_or_ilim_sel),
    .busdata_or_wake_flag_in(sda_in),
    .busdata_or_wake_flag(busdata_or_wake_flag),
    .enable_power_good_in(en_in), .enable_power_good(enable_power_good),
    .tx_data_in(tx_data_in), .line_drv_enable_in(line_drv_enable_in),
    .line_drv(line_drv), .ilim_sel(ilim_sel), .line_in(line_in),
    .aux_line_in(aux_line_in), .line_rx_out(line_rx_out),
    .aux_rx_out(aux_rx_out), .clkout(clkout), .wake_detect(wake_detect),
    .v5_mv(v5_mv), .bus_target_addr(bus_target_addr), .bus_scl(bus_scl),
    .bus_sda(bus_sda));
  tcp_mcu_model i_mcu (
    .sys_clk(sys_clk), .mode_cmd(mode_cmd), .ext_en(ext_en),
    .tx_bit(tx_bit), .rts_bit(rts_bit), .en_pad(enable_power_good),
    .sda_pad(busdata_or_wake_flag), .mode_sel(mode_sel),
    .tx_data_in(tx_data_in), .line_drv_enable_in(line_drv_enable_in),
    .enable_power_good_in(en_in), .busdata_in(sda_in));
  //////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read note is taken off when the data cycle comes round
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    notes.push_back('{4'h0, 1'b0, e});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  // m set: pad expected floating or its level unpredictable, so only the enable is compared
  task automatic pad(input logic [3:0] s, input logic m, logic [7:0] e);
    @(posedge sys_clk);
    snap <= 1'b1;
    notes.push_back('{s, m, e});
    @(posedge sys_clk);
    snap <= 1'b0;
  endtask
  task automatic cmp_rd(input logic [7:0] e);
    n_checks++;
    if (reg_rdata !== e) begin
      num_errors++;
      $display("mismatch at %0t: read %h, want %h", $time, reg_rdata, e);
    end
  endtask
  task automatic cmp_pad(input logic [3:0] s, input logic m, logic [7:0] e);
    logic [7:0] o;
    case (s)
      S_AUX: o = {6'h00, aux_rx_out};
      S_RX:  o = {6'h00, line_rx_out};
      S_DRV: o = {6'h00, line_drv};
      S_CLK: o = {6'h00, clkout};
      S_WK:  o = {6'h00, busdata_or_wake_flag};
      S_EN:  o = {6'h00, enable_power_good};
      S_IL:  o = {6'h00, ilim_sel};
      S_BUS: o = {6'h00, bus_scl, bus_sda};
      default: o = {1'b0, bus_target_addr};
    endcase
    if (m) begin
      o = {7'h00, o[0]};
      e = {7'h00, e[0]};
    end
    n_checks++;
    if (o !== e) begin
      num_errors++;
      $display("mismatch at %0t: output %0d is %h, want %h", $time, s, o, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Watcher: pops the oldest note whenever a result is due
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_seen || snap) begin
      nt = notes.pop_front();
      if (nt.sel == 4'h0) cmp_rd(nt.v);
      else cmp_pad(nt.sel, nt.m, nt.v);
    end
  end
  // Watchdog: a hang counts as a failure
  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    {reset, ext_en} = 2'b11;
    {reg_wr, reg_rd, snap, mode_cmd, tx_bit, rts_bit} = 6'h00;
    {addr_sel_clkout_en, busclk_or_ilim_sel, line_in} = 3'b000;
    {aux_line_in, wake_detect} = 2'b00;
    {reg_addr, reg_wdata} = 16'h0000;
    v5_mv = 13'd4000;
    rs = 32'h0000_0203;
    tick(20);
    reset <= 1'b0;
    tick(6);
    // Pin mode: reset values, unmapped read, random pin sweep
    rd(`TCP_CTRL_OFS, `TCP_CTRL_RESET);
    rd(`TCP_STAT_OFS, 8'h04);
    rd(8'h08, 8'h00);
    repeat (12) begin
      rs = next_rand(rs);
      {busclk_or_ilim_sel, rts_bit, tx_bit, line_in, aux_line_in} <= rs[4:0];
      addr_sel_clkout_en <= rs[5];
      tick(6);
      pad(S_AUX, 1'b0, {6'h00, ~rs[0], 1'b1});
      pad(S_RX, 1'b0, {6'h00, ~rs[1], 1'b1});
      pad(S_DRV, ~rs[3], {6'h00, ~rs[2], rs[3]});
      pad(S_IL, 1'b0, rs[4] ? 8'h01 : 8'h02);
      pad(S_CLK, 1'b1, {7'h00, rs[5]});
    end
    wr(`TCP_CTRL_OFS, 8'h56);
    tick(4);
    pad(S_AUX, 1'b0, {6'h00, ~aux_line_in, 1'b1});
    pad(S_BUS, 1'b0, 8'h00);
    wr(`TCP_CTRL_OFS, `TCP_CTRL_RESET);
    // Count clock output edges over 2000 cycles
    addr_sel_clkout_en <= 1'b1;
    tick(6);
    cnt = 0;
    @(negedge sys_clk);
    prev = clkout.out;
    repeat (2000) begin
      @(negedge sys_clk);
      if (clkout.out === 1'b1 && prev === 1'b0) cnt++;
      prev = clkout.out;
    end
    n_checks++;
    if (cnt < 146 || cnt > 148) begin
      num_errors++;
      $display("mismatch at %0t: clock edges %0d", $time, cnt);
    end
    tick(1);
    wake_detect <= 1'b1;
    tick(1);
    wake_detect <= 1'b0;
    pad(S_WK, 1'b0, 8'h01);
    tick(250);
    pad(S_WK, 1'b1, 8'h00);
    // Serial mode: address, driver gating, output disables
    mode_cmd <= 1'b1;
    for (int a = 0; a < 2; a++) begin
      addr_sel_clkout_en <= a[0];
      tick(6);
      pad(S_ADR, 1'b0, {1'b0, TBASE[6:1], a[0]});
    end
    // Serial-mode wake sets the sticky status bit; writing one clears it
    wake_detect <= 1'b1;
    tick(1);
    wake_detect <= 1'b0;
    rd(`TCP_STAT_OFS, 8'h27);
    wr(`TCP_STAT_OFS, 8'h20);
    rd(`TCP_STAT_OFS, 8'h07);
    pad(S_BUS, 1'b0, {6'h00, busclk_or_ilim_sel, 1'b1});
    for (int i = 0; i < 4; i++) begin
      rs = next_rand(rs);
      tx_bit <= rs[0];
      rts_bit <= i[1];
      wr(`TCP_CTRL_OFS, {7'h28, i[0]});
      tick(4);
      pad(S_DRV, ~(i[0] & i[1]), {6'h00, ~rs[0], i[0] & i[1]});
    end
    // Non-inverting transmit, register limit and clock enable
    wr(`TCP_CTRL_OFS, 8'h59);
    tick(4);
    pad(S_DRV, 1'b0, {6'h00, tx_bit, 1'b1});
    pad(S_IL, 1'b0, 8'h02);
    pad(S_CLK, 1'b1, 8'h01);
    wr(`TCP_CTRL_OFS, 8'h52);
    tick(2);
    pad(S_AUX, 1'b1, 8'h00);
    wr(`TCP_CTRL_OFS, 8'h54);
    tick(2);
    pad(S_RX, 1'b1, 8'h00);
    pad(S_AUX, 1'b0, {6'h00, ~aux_line_in, 1'b1});
    // Outside party pulls the enable node low
    wr(`TCP_CTRL_OFS, 8'h51);
    ext_en <= 1'b0;
    tick(6);
    pad(S_DRV, 1'b1, 8'h00);
    ext_en <= 1'b1;
    tick(6);
    rd(`TCP_CTRL_OFS, `TCP_CTRL_RESET);
    // Rail sag, hysteresis band, recovery
    wr(`TCP_CTRL_OFS, 8'h51);
    tick(4);
    pad(S_DRV, 1'b0, {6'h00, ~tx_bit, 1'b1});
    v5_mv <= 13'd2999;
    tick(4);
    pad(S_EN, 1'b0, 8'h01);
    v5_mv <= 13'd3200;
    tick(4);
    pad(S_EN, 1'b0, 8'h01);
    pad(S_DRV, 1'b1, 8'h00);
    v5_mv <= 13'd3501;
    tick(4);
    pad(S_EN, 1'b1, 8'h00);
    tick(4);
    end_of_test();
  end
endmodule // transceiver_ctrl_pin_logic_bench
